// File: dsp_cfg.svh
// Offsets, field positions, reset values and counts of the dual-slope PWM.
// Assumes inclusion by bare name from the package and the design files.
`ifndef DSP_CFG_SVH
`define DSP_CFG_SVH

// ********************************************************************
// Register byte offsets (one aligned 32-bit word each)
// ********************************************************************
`define DSP_OFF_CTRL 8'h00
`define DSP_OFF_COUNT 8'h04
`define DSP_OFF_CMP_A 8'h08
`define DSP_OFF_CMP_B 8'h0c
`define DSP_OFF_CAPT_TOP 8'h10
`define DSP_OFF_FLAGS 8'h14
`define DSP_OFF_STATUS 8'h18

// ********************************************************************
// Field positions and widths
// ********************************************************************
`define DSP_CTRL_W 15
`define DSP_FLAGS_W 4
`define DSP_FLAG_OVF 0
`define DSP_FLAG_MATCH_A 1
`define DSP_FLAG_MATCH_B 2
`define DSP_FLAG_CAPT 3
`define DSP_STAT_DIR 0
`define DSP_STAT_WAVE_A 1
`define DSP_STAT_WAVE_B 2
`define DSP_WAVE_TOP_BIT 3

// ********************************************************************
// Modes and encodings
// ********************************************************************
`define DSP_MODE_CAPT_TOP 4'h8
`define DSP_MODE_CMPA_TOP 4'h9
`define DSP_OUT_OFF 2'h0
`define DSP_OUT_TOGGLE 2'h1
`define DSP_OUT_NONINV 2'h2
`define DSP_OUT_INV 2'h3
`define DSP_BOTTOM 16'h0000
`define DSP_MIN_TOP 16'h0003

// ********************************************************************
// Prescaler selects and divide-minus-one limits (1, 8, 64, 256, 1024)
// ********************************************************************
`define DSP_CS_STOP 3'h0
`define DSP_CS_DIV1 3'h1
`define DSP_CS_DIV8 3'h2
`define DSP_CS_DIV64 3'h3
`define DSP_CS_DIV256 3'h4
`define DSP_CS_DIV1024 3'h5
`define DSP_LIM_DIV1 10'h000
`define DSP_LIM_DIV8 10'h007
`define DSP_LIM_DIV64 10'h03f
`define DSP_LIM_DIV256 10'h0ff
`define DSP_LIM_DIV1024 10'h3ff

// ********************************************************************
// Reset values and clock
// ********************************************************************
`define DSP_RST_CTRL 15'h0000
`define DSP_RST_VALUE 16'h0000
`define DSP_RST_FLAGS 4'h0
`define DSP_CLK_PERIOD_NS 100

`endif

// File: dsp_pkg.sv
// Types shared by the dual-slope PWM files.
// Assumes dsp_cfg.svh is on the include path.
`include "dsp_cfg.svh"

package dsp_pkg;

  // ******************************************************************
  // Control word, software visible
  // ******************************************************************
  typedef struct packed {
    logic pin_dir_b;
    logic pin_dir_a;
    logic out_sel_b;
    logic out_sel_a;
    logic [2:0] clk_sel;
    logic [1:0] out_mode_a;
    logic [1:0] out_mode_b;
    logic [3:0] wave_mode_select;
  } dsp_ctrl_type;

  // ******************************************************************
  // Event flags
  // ******************************************************************
  typedef struct packed {
    logic capture_flag;
    logic match_flag_b;
    logic match_flag_a;
    logic overflow_flag;
  } dsp_flags_type;

  typedef enum logic {
    DSP_UP = 1'b0,
    DSP_DOWN = 1'b1
  } dsp_dir_type;

endpackage : dsp_pkg

// File: dsp_prescaler.sv
// Timer tick generator: divides core_clk by 1, 8, 64, 256 or 1024.
// Assumes clk_sel is held steady by software between changes.
`timescale 1ns/1ps
`include "dsp_cfg.svh"

module dsp_prescaler (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [2:0] clk_sel,
  output logic timer_tick
);
  import dsp_pkg::*;

  logic [9:0] div_count;
  logic [9:0] limit;
  logic run;

  always_comb begin
    run = 1'b1;
    unique case (clk_sel)
      `DSP_CS_DIV1: limit = `DSP_LIM_DIV1;
      `DSP_CS_DIV8: limit = `DSP_LIM_DIV8;
      `DSP_CS_DIV64: limit = `DSP_LIM_DIV64;
      `DSP_CS_DIV256: limit = `DSP_LIM_DIV256;
      `DSP_CS_DIV1024: limit = `DSP_LIM_DIV1024;
      default: begin
        limit = `DSP_LIM_DIV1;
        run = 1'b0;
      end
    endcase
  end

  // ******************************************************************
  // Divider; a stopped select parks the divider so restart is clean
  // ******************************************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_count <= 10'h000;
      timer_tick <= 1'b0;
    end else if (!run) begin
      div_count <= 10'h000;
      timer_tick <= 1'b0;
    end else if (div_count >= limit) begin
      div_count <= 10'h000;
      timer_tick <= 1'b1;
    end else begin
      div_count <= div_count + 10'h001;
      timer_tick <= 1'b0;
    end
  end

endmodule : dsp_prescaler

// File: dsp_pwm.sv
// Dual-slope, symmetric PWM counter with two compare channels and an
// Avalon-MM register slave.
// Assumes one clock, core_clk, with inputs synchronous to it, and a
// port pad outside that resolves out/oe onto the pin.
`timescale 1ns/1ps
`include "dsp_cfg.svh"

// Function
// - Symmetric dual-slope mode is active when wave mode select is 8 or 9.
// - Count rises from zero to the ceiling, then falls back to zero.
// - Ceiling is capture top value in mode 8, compare A in mode 9.
// - Count holds the ceiling for one tick, then counts down.
// - Non-inverting: clear on match counting up, set on match counting down.
// - Inverting: set on match counting up, clear on match counting down.
// - Output mode two gives non-inverted PWM, three gives inverted PWM.
// - Ceilings from 0x0003 up to the full 16-bit maximum are supported.
// - Compares reload from buffers at bottom; overflow flag set same tick.
// - Ceiling's own flag, match A or capture, is set at the ceiling.
// - Each channel's match flag is set when count equals its compare.
// - Waveform reaches pin only with direction output and output select.
// - Non-inverting: compare zero gives constant low, compare at ceiling gives high.
// - Timer tick is core clock divided by 1, 8, 64, 256 or 1024.
// - Fully synchronous; tick only enables counting, waveforms, flags and reload.
// - Output period is twice the ceiling in timer ticks.
// - Output mode zero leaves the pin under normal port control.
// - Output mode one: A toggles if top mode bit set, else off; B off.
module dsp_pwm #(
  parameter int CW = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic port_out_a,
  input wire logic port_out_b,
  output logic wave_pin_a_out,
  output logic wave_pin_a_oe,
  output logic wave_pin_b_out,
  output logic wave_pin_b_oe,
  output logic wave_out_a,
  output logic wave_out_b,
  output dsp_pkg::dsp_flags_type flags
);
  import dsp_pkg::*;

  // ******************************************************************
  // State
  // ******************************************************************
  dsp_ctrl_type ctrl;
  dsp_dir_type dir;
  logic [CW-1:0] count_value;
  logic [CW-1:0] capture_top_value;
  logic [CW-1:0] cmp_buf [2];
  logic [CW-1:0] cmp_act [2];
  logic [1:0] wave;
  logic timer_tick;

  logic pfc_mode;
  logic [CW-1:0] top;
  logic at_top;
  logic at_bottom;
  logic step;
  logic [1:0] match;
  logic [1:0] out_mode [2];
  logic [1:0] connected;
  logic [1:0] out_sel;
  dsp_flags_type flag_set;
  dsp_flags_type flag_clr;

  logic commit_wr;
  logic [31:0] next_readdata;
  logic [31:0] merged_ctrl;
  logic [31:0] merged_cmp_a;
  logic [31:0] merged_cmp_b;
  logic [31:0] merged_capt;

  // Byte-lane merge of a write into a 32-bit view of a register
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  function automatic logic [31:0] widen(input logic [CW-1:0] v);
    return {{(32-CW){1'b0}}, v};
  endfunction : widen

  // ******************************************************************
  // Prescaler
  // ******************************************************************
  dsp_prescaler u_prescaler (
    .core_clk(core_clk),
    .nrst(nrst),
    .clk_sel(ctrl.clk_sel),
    .timer_tick(timer_tick)
  );

  // ******************************************************************
  // Count decode
  // ******************************************************************
  assign pfc_mode = (ctrl.wave_mode_select == `DSP_MODE_CAPT_TOP) ||
                    (ctrl.wave_mode_select == `DSP_MODE_CMPA_TOP);
  assign top = (ctrl.wave_mode_select == `DSP_MODE_CAPT_TOP) ?
               capture_top_value : cmp_act[0];
  // Reverse on >= so a ceiling lowered below the count cannot run away
  assign at_top = (count_value >= top);
  assign at_bottom = (count_value == CW'(`DSP_BOTTOM));
  assign step = timer_tick && pfc_mode;
  assign out_mode[0] = ctrl.out_mode_a;
  assign out_mode[1] = ctrl.out_mode_b;
  assign out_sel = {ctrl.out_sel_b, ctrl.out_sel_a};

  // ******************************************************************
  // Counter and direction
  // ******************************************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dir <= DSP_UP;
      count_value <= CW'(`DSP_RST_VALUE);
    end else if (step) begin
      unique case (dir)
        DSP_UP: begin
          if (at_top) begin
            dir <= DSP_DOWN;
            count_value <= count_value - CW'(1);
          end else begin
            count_value <= count_value + CW'(1);
          end
        end
        DSP_DOWN: begin
          if (at_bottom) begin
            dir <= DSP_UP;
            count_value <= count_value + CW'(1);
          end else begin
            count_value <= count_value - CW'(1);
          end
        end
      endcase
    end
  end

  // ******************************************************************
  // Compare double buffer
  // ******************************************************************
  // Outside modes 8/9 the active value follows the buffer at once
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmp_act[0] <= CW'(`DSP_RST_VALUE);
      cmp_act[1] <= CW'(`DSP_RST_VALUE);
    end else if (!pfc_mode || (step && at_bottom)) begin
      cmp_act[0] <= cmp_buf[0];
      cmp_act[1] <= cmp_buf[1];
    end
  end

  // ******************************************************************
  // Compare channels
  // ******************************************************************
  // At zero a match counts as rising and at the ceiling as falling, which
  // yields the constant levels for compare values of zero and the ceiling
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic eff_up;
    assign match[ch] = (count_value == cmp_act[ch]);
    assign eff_up = at_bottom || (!at_top && (dir == DSP_UP));

    if (ch == 0) begin : g_conn_a
      assign connected[ch] = out_mode[ch][1] ||
        ((out_mode[ch] == `DSP_OUT_TOGGLE) &&
         ctrl.wave_mode_select[`DSP_WAVE_TOP_BIT]);
    end else begin : g_conn_b
      assign connected[ch] = out_mode[ch][1];
    end

    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        wave[ch] <= 1'b0;
      end else if (step && match[ch]) begin
        unique case (out_mode[ch])
          `DSP_OUT_NONINV: wave[ch] <= !eff_up;
          `DSP_OUT_INV: wave[ch] <= eff_up;
          `DSP_OUT_TOGGLE: begin
            if (connected[ch]) begin
              wave[ch] <= !wave[ch];
            end
          end
          `DSP_OUT_OFF: wave[ch] <= wave[ch];
        endcase
      end
    end
  end

  // ******************************************************************
  // Pins and outputs
  // ******************************************************************
  // Output mode 2 and 3 select the polarity above; pin takes the wave
  // only with the channel connected and its output select set
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wave_pin_a_out <= 1'b0;
      wave_pin_b_out <= 1'b0;
      wave_pin_a_oe <= 1'b0;
      wave_pin_b_oe <= 1'b0;
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end else begin
      wave_pin_a_out <= (connected[0] && out_sel[0]) ?
                        wave[0] : port_out_a;
      wave_pin_b_out <= (connected[1] && out_sel[1]) ?
                        wave[1] : port_out_b;
      wave_pin_a_oe <= ctrl.pin_dir_a;
      wave_pin_b_oe <= ctrl.pin_dir_b;
      wave_out_a <= wave[0];
      wave_out_b <= wave[1];
    end
  end

  // ******************************************************************
  // Flags
  // ******************************************************************
  always_comb begin
    flag_set = '0;
    flag_set.overflow_flag = step && at_bottom;
    flag_set.match_flag_a = step && match[0];
    flag_set.match_flag_b = step && match[1];
    if (step && (count_value == top)) begin
      if (ctrl.wave_mode_select == `DSP_MODE_CMPA_TOP) begin
        flag_set.match_flag_a = 1'b1;
      end else begin
        flag_set.capture_flag = 1'b1;
      end
    end
  end

  always_comb begin
    flag_clr = '0;
    if (commit_wr && (avs_address == `DSP_OFF_FLAGS) && avs_byteenable[0]) begin
      flag_clr = dsp_flags_type'(avs_writedata[`DSP_FLAGS_W-1:0]);
    end
  end

  // A hardware event in the cycle of a software clear is kept
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flags <= dsp_flags_type'(`DSP_RST_FLAGS);
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  // ******************************************************************
  // Avalon-MM slave
  // ******************************************************************
  // Every access waits exactly one cycle; read data is registered
  assign commit_wr = avs_write && !avs_waitrequest;

  // ******************************************************************
  // Write data merge
  // ******************************************************************
  // Each register's 32-bit view with the written byte lanes merged in,
  // so a partial write keeps the lanes that were not enabled
  assign merged_ctrl = lane_merge(32'(ctrl), avs_writedata, avs_byteenable);
  assign merged_cmp_a = lane_merge(widen(cmp_buf[0]), avs_writedata,
                                   avs_byteenable);
  assign merged_cmp_b = lane_merge(widen(cmp_buf[1]), avs_writedata,
                                   avs_byteenable);
  assign merged_capt = lane_merge(widen(capture_top_value), avs_writedata,
                                  avs_byteenable);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= dsp_ctrl_type'(`DSP_RST_CTRL);
      cmp_buf[0] <= CW'(`DSP_RST_VALUE);
      cmp_buf[1] <= CW'(`DSP_RST_VALUE);
      capture_top_value <= CW'(`DSP_RST_VALUE);
    end else if (commit_wr) begin
      unique case (avs_address)
        `DSP_OFF_CTRL: begin
          ctrl <= dsp_ctrl_type'(merged_ctrl[`DSP_CTRL_W-1:0]);
        end
        `DSP_OFF_CMP_A: begin
          cmp_buf[0] <= merged_cmp_a[CW-1:0];
        end
        `DSP_OFF_CMP_B: begin
          cmp_buf[1] <= merged_cmp_b[CW-1:0];
        end
        `DSP_OFF_CAPT_TOP: begin
          capture_top_value <= merged_capt[CW-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    unique case (avs_address)
      `DSP_OFF_CTRL: next_readdata = 32'(ctrl);
      `DSP_OFF_COUNT: next_readdata = widen(count_value);
      `DSP_OFF_CMP_A: next_readdata = widen(cmp_buf[0]);
      `DSP_OFF_CMP_B: next_readdata = widen(cmp_buf[1]);
      `DSP_OFF_CAPT_TOP: next_readdata = widen(capture_top_value);
      `DSP_OFF_FLAGS: next_readdata = 32'(flags);
      `DSP_OFF_STATUS: begin
        next_readdata[`DSP_STAT_DIR] = (dir == DSP_DOWN);
        next_readdata[`DSP_STAT_WAVE_A] = wave[0];
        next_readdata[`DSP_STAT_WAVE_B] = wave[1];
      end
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

endmodule : dsp_pwm

// File: dsp_pwm_checker.sv
// Checker for dsp_pwm: bus handshake, read data, flag clearing, pin enables.
// Assumes it is bound to dsp_pwm and sees only that module's ports.
`timescale 1ns/1ps
`include "dsp_cfg.svh"

module dsp_pwm_checker #(
  parameter int CW = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic wave_pin_a_oe,
  input wire logic wave_pin_b_oe,
  input wire dsp_pkg::dsp_flags_type flags
);
  import dsp_pkg::*;
  logic wr_ok;
  logic ctl_wr;
  logic flag_wr;
  logic [3:0] clr;
  assign wr_ok = avs_write && !avs_waitrequest;
  assign ctl_wr = wr_ok && avs_address == `DSP_OFF_CTRL;
  assign flag_wr = wr_ok && avs_address == `DSP_OFF_FLAGS;
  // Flag port is the flag register itself, so a clear shows one cycle later; clears look one and two back
  assign clr = (flag_wr && avs_byteenable[0]) ? avs_writedata[3:0] : 4'h0;

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence req_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence one_wait;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  bus_answer_a: assert property (req_taken |=> one_wait)
    else $error("waitrequest did not drop for exactly one cycle");
  bus_idle_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  rd_unmapped_a: assert property (avs_read && !avs_waitrequest &&
    avs_address > 8'h18 |-> avs_readdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  rd_upper_a: assert property (avs_read && !avs_waitrequest |->
    avs_readdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  ovf_clear_a: assert property ($fell(flags.overflow_flag) |->
    $past(clr[0]) || $past(clr[0], 2))
    else $error("overflow flag fell without a clear");
  mta_clear_a: assert property ($fell(flags.match_flag_a) |->
    $past(clr[1]) || $past(clr[1], 2))
    else $error("match flag a fell without a clear");
  mtb_clear_a: assert property ($fell(flags.match_flag_b) |->
    $past(clr[2]) || $past(clr[2], 2))
    else $error("match flag b fell without a clear");
  cap_clear_a: assert property ($fell(flags.capture_flag) |->
    $past(clr[3]) || $past(clr[3], 2))
    else $error("capture flag fell without a clear");
  dir_a_oe_a: assert property ($changed(wave_pin_a_oe) |->
    $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("pin a enable changed without a control write");
  dir_b_oe_a: assert property ($changed(wave_pin_b_oe) |->
    $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("pin b enable changed without a control write");
endmodule : dsp_pwm_checker

bind dsp_pwm dsp_pwm_checker #(.CW(CW)) chk_u (
  .core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .wave_pin_a_oe(wave_pin_a_oe), .wave_pin_b_oe(wave_pin_b_oe),
  .flags(flags)
);

// File: tb.sv
// Self-checking bench for dsp_pwm: registers, waveforms, flags and pins.
// Assumes the package, design and checker are compiled before it.
`timescale 1ns/1ps
`include "dsp_cfg.svh"

module tb;
  import dsp_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic port_out_a = 1'b0;
  logic port_out_b = 1'b0;
  logic pa_out, pa_oe, pb_out, pb_oe, wave_a, wave_b;
  dsp_flags_type flags;
  int mismatches = 0;
  int samples_checked = 0;
  int exp_q[$];
  logic [31:0] q;
  int top, cmp, om, cs, md, nt, hi, lo, n;

  dsp_pwm #(.CW(16)) dut_u (
    .core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port_out_a(port_out_a), .port_out_b(port_out_b),
    .wave_pin_a_out(pa_out), .wave_pin_a_oe(pa_oe),
    .wave_pin_b_out(pb_out), .wave_pin_b_oe(pb_oe),
    .wave_out_a(wave_a), .wave_out_b(wave_b), .flags(flags)
  );

  always #50 core_clk = ~core_clk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Request is held until waitrequest is sampled low, then released
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] be);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask : rd

  task automatic wt(input logic b, input logic v, output int c);
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while ((b ? wave_b : wave_a) !== v);
  endtask : wt

  task automatic meas(input logic b, output int h, output int l);
    int c;
    wt(b, 1'b0, c);
    wt(b, 1'b1, c);
    wt(b, 1'b0, h);
    wt(b, 1'b1, l);
  endtask : meas

  // sd packs {dir_b, dir_a, sel_b, sel_a}
  function automatic logic [31:0] ctl(input int wm, ma, mb, c, sd);
    return {17'h0, sd[3:0], c[2:0], ma[1:0], mb[1:0], wm[3:0]};
  endfunction : ctl

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (90000) @(posedge core_clk);
    mismatches++;
    results();
  end

  initial begin
    n = $urandom(32'h8092695d);
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      rd(8'(i * 4));
      chk(q, 32'h0);
    end
    wr(`DSP_OFF_COUNT, 32'hffff);
    wr(`DSP_OFF_CMP_A, 32'habcd1234);
    wr(`DSP_OFF_CMP_B, 32'h5678);
    bus(1'b1, `DSP_OFF_CMP_B, 32'h0000ab00, 4'h2);
    rd(`DSP_OFF_COUNT);
    chk(q, 32'h0);
    rd(`DSP_OFF_CMP_A);
    chk(q, 32'h1234);
    rd(`DSP_OFF_CMP_B);
    chk(q, 32'hab78);
    // Compare at bottom and at ceiling give steady levels
    for (int k = 0; k < 4; k++) begin
      cmp = k[0] ? 8 : 0;
      om = 2 + k / 2;
      wr(`DSP_OFF_CTRL, 32'h0);
      wr(`DSP_OFF_CMP_A, 32'h8);
      wr(`DSP_OFF_CMP_B, cmp);
      wr(`DSP_OFF_CTRL, ctl(9, 2, om, 1, 0));
      repeat (22) @(posedge core_clk);
      repeat (16) begin
        @(posedge core_clk);
        chk(wave_b, (cmp == 8) ^ (om == 3));
      end
    end
    // Last three passes pin the slow dividers with a short ceiling
    for (int it = 0; it < 8; it++) begin
      top = it < 5 ? 3 + $urandom % 16 : 3;
      cmp = 1 + $urandom % (top - 1);
      om = 2 + $urandom % 2;
      cs = it < 5 ? 1 + $urandom % 2 : it - 2;
      md = 8 + it % 2;
      wr(`DSP_OFF_CTRL, 32'h0);
      wr(`DSP_OFF_CAPT_TOP, top);
      wr(`DSP_OFF_CMP_A, md == 9 ? top : cmp);
      wr(`DSP_OFF_CMP_B, cmp);
      wr(`DSP_OFF_FLAGS, 32'hf);
      wr(`DSP_OFF_CTRL, ctl(md, om, om, cs, 0));
      nt = cs < 4 ? 1 << (3 * (cs - 1)) : 1 << (2 * cs);
      exp_q.push_back(2 * nt * (om == 2 ? cmp : top - cmp));
      exp_q.push_back(2 * nt * top);
      repeat (2) meas(md == 9, hi, lo);
      chk(hi, exp_q.pop_front());
      chk(hi + lo, exp_q.pop_front());
      wr(`DSP_OFF_CTRL, ctl(md, om, om, 0, 0));
      rd(`DSP_OFF_FLAGS);
      chk(q, md == 9 ? 32'h7 : 32'hf);
      chk(32'(flags), md == 9 ? 32'h7 : 32'hf);
      wr(`DSP_OFF_FLAGS, 32'hf);
      rd(`DSP_OFF_FLAGS);
      chk(q, 32'h0);
    end
    // Pin routing: port data versus waveform, per output mode
    wr(`DSP_OFF_CMP_A, 32'ha);
    wr(`DSP_OFF_CMP_B, 32'h4);
    for (int k = 0; k < 3; k++) begin
      wr(`DSP_OFF_CTRL, ctl(9, k, k == 1 ? 1 : 2, 1, k == 2 ? 9 : 15));
      for (int j = 0; j < 4; j++) begin
        port_out_a <= 1'($urandom);
        port_out_b <= 1'($urandom);
        repeat (3) @(posedge core_clk);
        if (k == 0) chk(pa_out, port_out_a);
        if (k == 1) chk(pa_out, wave_a);
        chk({pa_oe, pb_oe}, k == 2 ? 1 : 3);
        chk(pb_out, k == 0 ? wave_b : port_out_b);
      end
      if (k == 1) begin
        repeat (2) meas(1'b0, hi, lo);
        chk(hi, 20);
        chk(lo, 20);
      end
    end
    results();
  end
endmodule : tb
